//--- pkg/mmp_pkg.sv
// package: types, offsets and reset values of the module management block
package mmp_pkg;

  // 2-wire slave address and memory layout
  localparam logic [6:0] DEV_ADDR  = 7'h50;
  localparam int         MEM_DEPTH = 32;
  localparam int         NUM_MON   = 5;
  localparam logic [4:0] ALM_FLAGS = 5'h05;
  localparam logic [4:0] WRN_FLAGS = 5'h06;
  localparam logic [4:0] HI_ALM    = 5'h07;
  localparam logic [4:0] LO_ALM    = 5'h0c;
  localparam logic [4:0] HI_WRN    = 5'h11;
  localparam logic [4:0] LO_WRN    = 5'h16;
  localparam logic [4:0] WP_DEF    = 5'h07;
  localparam logic [7:0] HI_DEF    = 8'hff;
  localparam logic [7:0] LO_DEF    = 8'h00;

  // register offsets
  localparam logic [7:0] PINS_OFF  = 8'h00;
  localparam logic [7:0] ISTAT_OFF = 8'h04;
  localparam logic [7:0] IMASK_OFF = 8'h08;
  localparam logic [7:0] MADDR_OFF = 8'h0c;
  localparam logic [7:0] MDATA_OFF = 8'h10;
  localparam logic [7:0] WP_OFF    = 8'h14;
  localparam logic [1:0] RESP_OK   = 2'h0;
  localparam logic [1:0] RESP_ERR  = 2'h2;

  // interrupt event bits
  localparam int EV_FLAG = 0;
  localparam int EV_WR   = 1;
  localparam int EV_LOS  = 2;

  typedef logic [NUM_MON-1:0][7:0] mmp_mon_t;

  typedef enum logic [2:0] {
    I_IDLE, I_ADDR, I_ACK, I_RX, I_TX, I_RACK, I_TXLD
  } mmp_i2c_e;

  typedef struct packed {
    logic [7:0]  awaddr;
    logic        awvalid;
    logic [31:0] wdata;
    logic [3:0]  wstrb;
    logic        wvalid;
    logic        bready;
    logic [7:0]  araddr;
    logic        arvalid;
    logic        rready;
  } mmp_axi_req_s;

  typedef struct packed {
    logic        awready;
    logic        wready;
    logic        bvalid;
    logic [1:0]  bresp;
    logic        arready;
    logic        rvalid;
    logic [31:0] rdata;
    logic [1:0]  rresp;
  } mmp_axi_rsp_s;

  typedef struct packed {
    logic [1:0]                 scl_s;
    logic [1:0]                 sda_s;
    logic [1:0]                 sel_s;
    logic [1:0]                 txo_s;
    logic [1:0]                 pd_s;
    logic [1:0]                 det_s;
    logic                       scl_q;
    logic                       sda_q;
    logic                       pd_q;
    logic                       det_q;
    mmp_i2c_e                   st;
    logic [2:0]                 bitc;
    logic [7:0]                 sh;
    logic [4:0]                 ptr;
    logic                       rw;
    logic                       first;
    logic                       sda_oe;
    logic [MEM_DEPTH-1:0][7:0]  mem;
    logic [4:0]                 wp;
    logic [4:0]                 maddr;
    logic [2:0]                 ist;
    logic [2:0]                 imask;
    mmp_axi_rsp_s               axi;
    logic                       laser_on;
    logic                       standby;
    logic                       int_n;
    logic                       present_n;
    logic                       sig_lost;
    logic                       irq;
  } mmp_state_s;

  function automatic mmp_state_s mmp_rst_val();
    mmp_state_s s;
    s       = '0;
    s.scl_s = 2'h3;
    s.sda_s = 2'h3;
    s.sel_s = 2'h3;
    s.txo_s = 2'h3;
    s.scl_q = 1'b1;
    s.sda_q = 1'b1;
    s.st    = I_IDLE;
    s.wp    = WP_DEF;
    s.int_n = 1'b1;
    s.sig_lost = 1'b1;
    for (int i = 0; i < NUM_MON; i++) begin
      s.mem[HI_ALM + 5'(i)] = HI_DEF;
      s.mem[HI_WRN + 5'(i)] = HI_DEF;
      s.mem[LO_ALM + 5'(i)] = LO_DEF;
      s.mem[LO_WRN + 5'(i)] = LO_DEF;
    end
    return s;
  endfunction

  localparam mmp_state_s ST_RST = mmp_rst_val();

endpackage

//--- rtl/mmp_top.sv
// module management pins, 2-wire diagnostic memory and register slave
`timescale 1ns/1ps
`default_nettype none

// Function
// - answer 2-wire traffic only while selected low
// - interrupt pin low while any flag set
// - transmit_off switches laser source off
// - power-down high holds low-power standby
// - power-down falling edge resets everything but the pending register bus responses
// - presence output driven low permanently
// - provide receive_signal_lost status output
// - receive_signal_lost low normal, high lost
// - capture on rising edge, unprotected bytes
// - read data changes on falling edge
// - data line bidirectional, start/stop mark frames
// - memory of individually addressed bytes
// - random and sequential access from zero
// - live monitor values readable over 2-wire
// - alarm and warning flags outside range
module mmp_top (
  // clock and reset
  input  wire logic                  aclk,
  input  wire logic                  aresetn,
  // register bus
  input  wire mmp_pkg::mmp_axi_req_s axi_req,
  output var  mmp_pkg::mmp_axi_rsp_s axi_rsp,
  output logic                       irq,
  // module control pins
  input  wire logic                  select_n,
  input  wire logic                  transmit_off,
  input  wire logic                  power_down,
  input  wire logic                  signal_detect,
  output logic                       laser_on,
  output logic                       standby,
  output logic                       int_n,
  output logic                       present_n,
  output logic                       receive_signal_lost,
  // 2-wire serial pins
  input  wire logic                  scl_i,
  input  wire logic                  sda_i,
  output logic                       sda_o,
  output logic                       sda_oe,
  // monitored values
  input  wire mmp_pkg::mmp_mon_t     mon
);

  ////////////////////////////////////////////////////////////////////////////
  mmp_pkg::mmp_state_s r_reg;
  mmp_pkg::mmp_state_s r_next;

  function automatic logic out_of(input logic [7:0] v,
                                  input logic [7:0] hi,
                                  input logic [7:0] lo);
    return (v > hi) || (v < lo);
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  always_comb begin
    logic       scl;
    logic       sda;
    logic       pd;
    logic       rise;
    logic       fall;
    logic       start;
    logic       stop;
    logic       wr_ev;
    logic       hit;
    logic [7:0] b;
    logic [7:0] rd;
    logic [4:0] af;
    logic [4:0] wf;
    logic [2:0] ev;
    logic [2:0] clr;
    logic [4:0] ld;
    scl   = r_reg.scl_s[1];
    sda   = r_reg.sda_s[1];
    pd    = r_reg.pd_s[1];
    rise  = scl & ~r_reg.scl_q;
    fall  = ~scl & r_reg.scl_q;
    start = r_reg.sda_q & ~sda & scl & r_reg.scl_q;
    stop  = ~r_reg.sda_q & sda & scl & r_reg.scl_q;
    wr_ev = 1'b0;
    hit   = 1'b1;
    b     = 8'h00;
    rd    = 8'h00;
    af    = 5'h00;
    wf    = 5'h00;
    clr   = 3'h0;
    ev    = 3'h0;
    ld    = r_reg.ptr;
    r_next = r_reg;

    // pin synchronisers
    r_next.scl_s = {r_reg.scl_s[0], scl_i};
    r_next.sda_s = {r_reg.sda_s[0], sda_i};
    r_next.sel_s = {r_reg.sel_s[0], select_n};
    r_next.txo_s = {r_reg.txo_s[0], transmit_off};
    r_next.pd_s  = {r_reg.pd_s[0], power_down};
    r_next.det_s = {r_reg.det_s[0], signal_detect};
    r_next.scl_q = scl;
    r_next.sda_q = sda;
    r_next.pd_q  = pd;
    r_next.det_q = r_reg.det_s[1];

    // live values and range flags
    for (int i = 0; i < mmp_pkg::NUM_MON; i++) begin
      r_next.mem[i] = mon[i];
      af[i] = out_of(mon[i], r_reg.mem[mmp_pkg::HI_ALM + 5'(i)],
                     r_reg.mem[mmp_pkg::LO_ALM + 5'(i)]);
      wf[i] = out_of(mon[i], r_reg.mem[mmp_pkg::HI_WRN + 5'(i)],
                     r_reg.mem[mmp_pkg::LO_WRN + 5'(i)]);
    end
    r_next.mem[mmp_pkg::ALM_FLAGS] = {3'h0, af};
    r_next.mem[mmp_pkg::WRN_FLAGS] = {3'h0, wf};

    // 2-wire slave
    if (r_reg.sel_s[1]) begin
      r_next.st     = mmp_pkg::I_IDLE;
      r_next.sda_oe = 1'b0;
    end else if (start) begin
      r_next.st     = mmp_pkg::I_ADDR;
      r_next.bitc   = 3'h0;
      r_next.sda_oe = 1'b0;
    end else if (stop) begin
      r_next.st     = mmp_pkg::I_IDLE;
      r_next.sda_oe = 1'b0;
    end else if (rise) begin
      case (r_reg.st)
        mmp_pkg::I_ADDR, mmp_pkg::I_RX: begin
          b           = {r_reg.sh[6:0], sda};
          r_next.sh   = b;
          r_next.bitc = r_reg.bitc + 3'h1;
          if (r_reg.bitc == 3'h7) begin
            r_next.st = mmp_pkg::I_ACK;
            if (r_reg.st == mmp_pkg::I_ADDR) begin
              r_next.rw    = b[0];
              r_next.first = 1'b1;
              if (b[7:1] != mmp_pkg::DEV_ADDR) begin
                r_next.st = mmp_pkg::I_IDLE;
              end
            end else if (r_reg.first) begin
              r_next.ptr   = b[4:0];
              r_next.first = 1'b0;
            end else begin
              if (r_reg.ptr >= r_reg.wp) begin
                r_next.mem[r_reg.ptr] = b;
                wr_ev = 1'b1;
              end
              r_next.ptr = r_reg.ptr + 5'h01;
            end
          end
        end
        mmp_pkg::I_TX: begin
          r_next.bitc = r_reg.bitc + 3'h1;
          if (r_reg.bitc == 3'h7) begin
            r_next.st = mmp_pkg::I_RACK;
          end
        end
        mmp_pkg::I_RACK: begin
          r_next.st = sda ? mmp_pkg::I_IDLE : mmp_pkg::I_TXLD;
        end
        default: begin
        end
      endcase
    end else if (fall) begin
      case (r_reg.st)
        mmp_pkg::I_ACK: begin
          r_next.sda_oe = ~r_reg.sda_oe;
          if (r_reg.sda_oe) begin
            r_next.bitc = 3'h0;
            r_next.st   = r_reg.rw ? mmp_pkg::I_TXLD : mmp_pkg::I_RX;
          end
        end
        mmp_pkg::I_TX: begin
          r_next.sda_oe = ~r_reg.sh[7];
          r_next.sh     = {r_reg.sh[6:0], 1'b0};
        end
        mmp_pkg::I_RACK: begin
          r_next.sda_oe = 1'b0;
        end
        default: begin
        end
      endcase
      if (r_reg.st == mmp_pkg::I_TXLD ||
          (r_reg.st == mmp_pkg::I_ACK && r_reg.sda_oe && r_reg.rw)) begin
        r_next.sh     = {r_reg.mem[ld][6:0], 1'b0};
        r_next.sda_oe = ~r_reg.mem[ld][7];
        r_next.ptr    = ld + 5'h01;
        r_next.bitc   = 3'h0;
        r_next.st     = mmp_pkg::I_TX;
      end
    end

    ////////////////////////////////////////////////////////////////////////
    // register bus slave
    r_next.axi.awready = axi_req.awvalid & axi_req.wvalid &
                         ~r_reg.axi.awready & ~r_reg.axi.bvalid;
    r_next.axi.wready  = r_next.axi.awready;
    if (r_reg.axi.bvalid && axi_req.bready) begin
      r_next.axi.bvalid = 1'b0;
    end
    if (r_reg.axi.awready) begin
      r_next.axi.bvalid = 1'b1;
      case (axi_req.awaddr)
        mmp_pkg::PINS_OFF: begin
        end
        mmp_pkg::ISTAT_OFF: clr = axi_req.wstrb[0] ? axi_req.wdata[2:0] : 3'h0;
        mmp_pkg::IMASK_OFF: begin
          if (axi_req.wstrb[0]) begin
            r_next.imask = axi_req.wdata[2:0];
          end
        end
        mmp_pkg::MADDR_OFF: begin
          if (axi_req.wstrb[0]) begin
            r_next.maddr = axi_req.wdata[4:0];
          end
        end
        mmp_pkg::MDATA_OFF: begin
          if (axi_req.wstrb[0]) begin
            r_next.mem[r_reg.maddr] = axi_req.wdata[7:0];
          end
        end
        mmp_pkg::WP_OFF: begin
          if (axi_req.wstrb[0]) begin
            r_next.wp = axi_req.wdata[4:0];
          end
        end
        default: hit = 1'b0;
      endcase
      r_next.axi.bresp = hit ? mmp_pkg::RESP_OK : mmp_pkg::RESP_ERR;
    end
    hit = 1'b1;
    r_next.axi.arready = axi_req.arvalid & ~r_reg.axi.arready &
                         ~r_reg.axi.rvalid;
    if (r_reg.axi.rvalid && axi_req.rready) begin
      r_next.axi.rvalid = 1'b0;
    end
    if (r_reg.axi.arready) begin
      case (axi_req.araddr)
        mmp_pkg::PINS_OFF: rd = {3'h0, r_reg.sig_lost, r_reg.standby,
                                 r_reg.laser_on, r_reg.txo_s[1],
                                 r_reg.sel_s[1]};
        mmp_pkg::ISTAT_OFF: rd = {5'h00, r_reg.ist};
        mmp_pkg::IMASK_OFF: rd = {5'h00, r_reg.imask};
        mmp_pkg::MADDR_OFF: rd = {3'h0, r_reg.maddr};
        mmp_pkg::MDATA_OFF: rd = r_reg.mem[r_reg.maddr];
        mmp_pkg::WP_OFF:    rd = {3'h0, r_reg.wp};
        default:            hit = 1'b0;
      endcase
      r_next.axi.rvalid = 1'b1;
      r_next.axi.rdata  = {24'h000000, rd};
      r_next.axi.rresp  = hit ? mmp_pkg::RESP_OK : mmp_pkg::RESP_ERR;
    end

    ////////////////////////////////////////////////////////////////////////
    // events, pins and interrupt
    ev[mmp_pkg::EV_FLAG] = |((af | wf) &
                            ~(r_reg.mem[mmp_pkg::ALM_FLAGS][4:0] |
                              r_reg.mem[mmp_pkg::WRN_FLAGS][4:0]));
    ev[mmp_pkg::EV_WR]   = wr_ev;
    ev[mmp_pkg::EV_LOS]  = r_reg.det_s[1] ^ r_reg.det_q;
    r_next.ist       = (r_reg.ist & ~clr) | ev;
    r_next.irq       = |(r_next.ist & r_next.imask);
    r_next.laser_on  = ~r_reg.txo_s[1] & ~pd;
    r_next.standby   = pd;
    r_next.int_n     = ~|(af | wf);
    r_next.present_n = 1'b0;
    r_next.sig_lost  = ~r_reg.det_s[1];

    // power-down release acts as a power cycle; bus responses survive, ready flags clear
    if (r_reg.pd_q && !pd) begin
      r_next     = mmp_pkg::ST_RST;
      r_next.axi = r_reg.axi;
      r_next.axi.awready = 1'b0;
      r_next.axi.wready  = 1'b0;
      r_next.axi.arready = 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      r_reg <= mmp_pkg::ST_RST;
    end else begin
      r_reg <= r_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  assign axi_rsp             = r_reg.axi;
  assign irq                 = r_reg.irq;
  assign laser_on            = r_reg.laser_on;
  assign standby             = r_reg.standby;
  assign int_n               = r_reg.int_n;
  assign present_n           = r_reg.present_n;
  assign receive_signal_lost = r_reg.sig_lost;
  assign sda_o               = 1'b0;
  assign sda_oe              = r_reg.sda_oe;

  ////////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  chk_desel_quiet: assert property (
    r_reg.sel_s[1] |=> !r_reg.sda_oe && r_reg.st == mmp_pkg::I_IDLE)
    else $error("slave active while deselected");
  chk_int_pin_flags: assert property (
    !r_reg.int_n == (|r_reg.mem[mmp_pkg::ALM_FLAGS][4:0] ||
                     |r_reg.mem[mmp_pkg::WRN_FLAGS][4:0]))
    else $error("interrupt pin disagrees with flags");
  chk_laser_off: assert property (
    r_reg.txo_s[1] |=> !r_reg.laser_on)
    else $error("laser on while transmit_off");
  chk_standby_hold: assert property (
    r_reg.pd_s[1] ##1 r_reg.pd_s[1] |=> r_reg.standby && !r_reg.laser_on)
    else $error("standby missing during power-down");
  chk_pd_reset: assert property (
    (r_reg.pd_q && !r_reg.pd_s[1]) |=> r_reg.st == mmp_pkg::I_IDLE &&
      r_reg.wp == mmp_pkg::WP_DEF && r_reg.ist == 3'h0)
    else $error("power-down release did not reset");
  chk_present_low: assert property (
    $past(aresetn) |-> !present_n)
    else $error("presence output not low");
  chk_los_level: assert property (
    $rose(r_reg.det_s[1]) |=> !r_reg.sig_lost ##0 $past(r_reg.sig_lost))
    else $error("loss of signal level wrong");
  chk_sda_on_fall: assert property (
    $rose(r_reg.sda_oe) |-> $past(r_reg.scl_q) && !$past(r_reg.scl_s[1]))
    else $error("data line driven outside falling clock");
  chk_irq_mask: assert property (
    r_reg.irq == |(r_reg.ist & r_reg.imask))
    else $error("interrupt output disagrees with status");
  chk_ptr_step: assert property (
    (r_reg.st == mmp_pkg::I_RX && !r_reg.first && r_reg.bitc == 3'h7 &&
     r_reg.scl_s[1] && !r_reg.scl_q && !r_reg.sel_s[1] &&
     !(r_reg.pd_q && !r_reg.pd_s[1]))
    |=> r_reg.ptr == $past(r_reg.ptr) + 5'h01)
    else $error("pointer did not advance after a byte");

endmodule

`default_nettype wire

//--- verification/mmp_host_model.sv
// 2-wire host board controller model for the management block
`timescale 1ns/1ps
`default_nettype none
module mmp_host_model (
  // clock
  input  wire logic aclk,
  // 2-wire pins
  input  wire logic sda_w,
  output logic      scl,
  output logic      sda_h
);
  initial begin
    scl   = 1'b1;
    sda_h = 1'b1;
  end
  ////////////////////////////////////////////////////////////////////////
  task automatic tick(input int n);
    repeat (n) @(posedge aclk);
  endtask
  // one bit: data moves only while the clock is low, sampled mid high
  task automatic bit_io(input logic b, output logic r);
    scl <= 1'b0;
    tick(2);
    sda_h <= b;
    tick(2);
    scl <= 1'b1;
    tick(2);
    r = sda_w;
    tick(2);
  endtask
  // start or repeated start when stop is 0, stop condition when 1
  task automatic frame(input logic stop);
    scl <= 1'b0;
    tick(3);
    sda_h <= ~stop;
    tick(3);
    scl <= 1'b1;
    tick(4);
    sda_h <= stop;
    tick(4);
  endtask
  // byte out, msb first, then the acknowledge slot
  task automatic put(input logic [7:0] d, output logic nak);
    logic r;
    for (int i = 7; i >= 0; i--) bit_io(d[i], r);
    bit_io(1'b1, nak);
  endtask
  // byte in, then ack or nack from the host
  task automatic get(input logic last, output logic [7:0] d);
    logic r;
    for (int i = 7; i >= 0; i--) bit_io(1'b1, d[i]);
    bit_io(last, r);
  endtask
endmodule
`default_nettype wire

//--- verification/mmp_top_test.sv
// self-checking bench of the module management block
`timescale 1ns/1ps
`default_nettype none
module mmp_top_test;
  logic                  aclk, aresetn, irq, select_n, transmit_off;
  logic                  power_down, signal_detect, laser_on, standby;
  logic                  int_n, present_n, los, scl, sda_h, sda_w;
  logic                  sda_o, sda_oe, nak;
  logic [7:0]            d, e, b;
  mmp_pkg::mmp_axi_req_s req;
  mmp_pkg::mmp_axi_rsp_s rsp;
  mmp_pkg::mmp_mon_t     mon;
  logic [33:0]           rq[$];
  logic [1:0]            bq[$];
  int                    error_cnt = 0;
  int                    cmp_count = 0;
  int                    cyc = 0;

  // open-drain data wire with pull-up
  assign sda_w = sda_h & ~(sda_oe & ~sda_o);

  mmp_top u_mmp_top (.aclk(aclk), .aresetn(aresetn), .axi_req(req),
    .axi_rsp(rsp), .irq(irq), .select_n(select_n),
    .transmit_off(transmit_off), .power_down(power_down),
    .signal_detect(signal_detect), .laser_on(laser_on),
    .standby(standby), .int_n(int_n), .present_n(present_n),
    .receive_signal_lost(los), .scl_i(scl), .sda_i(sda_w),
    .sda_o(sda_o), .sda_oe(sda_oe), .mon(mon));
  mmp_host_model u_mmp_host_model (.aclk(aclk), .sda_w(sda_w),
    .scl(scl), .sda_h(sda_h));

  ////////////////////////////////////////////////////////////////////////
  task automatic cmp(input logic [33:0] got, input logic [33:0] exp);
    cmp_count++;
    if (got !== exp) begin
      error_cnt++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic close_out();
    if (error_cnt == 0 && cmp_count > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  task automatic step(input int n);
    repeat (n) @(posedge aclk);
  endtask
  // register bus write; bready raised once the write is taken
  task automatic wr(input logic [7:0] a, input logic [31:0] v,
                    input logic [1:0] r = mmp_pkg::RESP_OK);
    bq.push_back(r);
    req.awaddr  <= a;
    req.wdata   <= v;
    req.awvalid <= 1'b1;
    req.wvalid  <= 1'b1;
    do begin
      @(posedge aclk);
      if (rsp.awready === 1'b1) req.awvalid <= 1'b0;
      if (rsp.wready === 1'b1) begin
        req.wvalid <= 1'b0;
        req.bready <= 1'b1;
      end
    end while (rsp.bvalid !== 1'b1);
    req.bready <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] v,
                    input logic [1:0] r = mmp_pkg::RESP_OK);
    rq.push_back({r, v});
    req.araddr  <= a;
    req.arvalid <= 1'b1;
    do begin
      @(posedge aclk);
      if (rsp.arready === 1'b1) begin
        req.arvalid <= 1'b0;
        req.rready  <= 1'b1;
      end
    end while (rsp.rvalid !== 1'b1);
    req.rready <= 1'b0;
  endtask
  task automatic mwr(input logic [4:0] a, input logic [7:0] v);
    wr(mmp_pkg::MADDR_OFF, {27'h0, a});
    wr(mmp_pkg::MDATA_OFF, {24'h0, v});
  endtask
  task automatic mrd(input logic [4:0] a, input logic [7:0] v);
    wr(mmp_pkg::MADDR_OFF, {27'h0, a});
    rd(mmp_pkg::MDATA_OFF, {24'h0, v});
  endtask
  // 2-wire write of two sequential bytes from pointer p
  task automatic lwr(input logic [4:0] p, input logic [7:0] v, w);
    u_mmp_host_model.frame(1'b0);
    u_mmp_host_model.put({mmp_pkg::DEV_ADDR, 1'b0}, nak);
    cmp(34'(nak), 34'h0);
    u_mmp_host_model.put({3'h0, p}, nak);
    u_mmp_host_model.put(v, nak);
    u_mmp_host_model.put(w, nak);
    cmp(34'(nak), 34'h0);
    u_mmp_host_model.frame(1'b1);
  endtask
  // random read of two sequential bytes from pointer p
  task automatic lrd(input logic [4:0] p, input logic [7:0] v, w);
    u_mmp_host_model.frame(1'b0);
    u_mmp_host_model.put({mmp_pkg::DEV_ADDR, 1'b0}, nak);
    u_mmp_host_model.put({3'h0, p}, nak);
    u_mmp_host_model.frame(1'b0);
    u_mmp_host_model.put({mmp_pkg::DEV_ADDR, 1'b1}, nak);
    u_mmp_host_model.get(1'b0, b);
    cmp(34'(b), 34'(v));
    u_mmp_host_model.get(1'b1, b);
    cmp(34'(b), 34'(w));
    u_mmp_host_model.frame(1'b1);
  endtask

  ////////////////////////////////////////////////////////////////////////
  initial begin
    aclk = 1'b0;
    forever #10 aclk = ~aclk;
  end
  // result watcher: oldest note against each bus response
  always @(posedge aclk) begin
    if (rsp.bvalid === 1'b1 && req.bready && bq.size() > 0) begin
      cmp(34'(rsp.bresp), 34'(bq.pop_front()));
    end
    if (rsp.rvalid === 1'b1 && req.rready && rq.size() > 0) begin
      cmp({rsp.rresp, rsp.rdata}, rq.pop_front());
    end
  end
  always @(posedge aclk) begin
    cyc <= cyc + 1;
    if (cyc == 30000) begin
      error_cnt++;
      close_out();
    end
  end

  ////////////////////////////////////////////////////////////////////////
  initial begin
    req = '0;
    req.wstrb = 4'hf;
    aresetn = 1'b0;
    select_n = 1'b1;
    transmit_off = 1'b1;
    power_down = 1'b0;
    signal_detect = 1'b0;
    void'($urandom(39));
    mon = '0;
    mon[0] = 8'($urandom);
    mon[1] = 8'h80;
    for (int i = 2; i < mmp_pkg::NUM_MON; i++) mon[i] = 8'($urandom);
    step(2);
    cmp({32'h0, present_n, los}, 34'h1);
    step(1);
    aresetn <= 1'b1;
    step(8);
    cmp({32'h0, laser_on, los}, 34'h1);
    transmit_off <= 1'b0;
    signal_detect <= 1'b1;
    step(8);
    cmp({32'h0, laser_on, los}, 34'h2);
    rd(mmp_pkg::PINS_OFF, 32'h05);
    // standby, then reset of all but the bus responses on the falling edge
    wr(mmp_pkg::WP_OFF, 32'd30);
    mwr(5'd27, 8'h5a);
    power_down <= 1'b1;
    step(8);
    cmp(34'(standby), 34'h1);
    power_down <= 1'b0;
    step(8);
    cmp(34'(standby), 34'h0);
    rd(mmp_pkg::WP_OFF, 32'h07);
    mrd(5'd27, 8'h00);
    wr(8'h18, 32'h0, mmp_pkg::RESP_ERR);
    rd(8'h18, 32'h0, mmp_pkg::RESP_ERR);
    wr(mmp_pkg::ISTAT_OFF, 32'h7);
    wr(mmp_pkg::IMASK_OFF, 32'h2);
    // not selected, then wrong device address
    u_mmp_host_model.frame(1'b0);
    u_mmp_host_model.put({mmp_pkg::DEV_ADDR, 1'b0}, nak);
    cmp(34'(nak), 34'h1);
    u_mmp_host_model.frame(1'b1);
    select_n <= 1'b0;
    step(4);
    u_mmp_host_model.frame(1'b0);
    u_mmp_host_model.put({mmp_pkg::DEV_ADDR ^ 7'h01, 1'b0}, nak);
    cmp(34'(nak), 34'h1);
    u_mmp_host_model.frame(1'b1);
    d = 8'($urandom);
    e = 8'($urandom);
    lwr(5'd27, d, e);
    mrd(5'd27, d);
    mrd(5'd28, e);
    // interrupt raised, masked, cleared
    rd(mmp_pkg::ISTAT_OFF, 32'h2);
    cmp(34'(irq), 34'h1);
    wr(mmp_pkg::IMASK_OFF, 32'h0);
    step(2);
    cmp(34'(irq), 34'h0);
    wr(mmp_pkg::ISTAT_OFF, 32'h2);
    wr(mmp_pkg::IMASK_OFF, 32'h2);
    step(2);
    cmp(34'(irq), 34'h0);
    // write with byte lane 0 off is ignored
    req.wstrb <= 4'he;
    wr(mmp_pkg::IMASK_OFF, 32'h5);
    req.wstrb <= 4'hf;
    rd(mmp_pkg::IMASK_OFF, 32'h2);
    // protection boundary: 29 below the limit, 30 at it
    wr(mmp_pkg::WP_OFF, 32'd30);
    lwr(5'd29, d, e);
    mrd(5'd29, 8'h00);
    mrd(5'd30, e);
    lrd(5'd27, d, e);
    lrd(5'd0, mon[0], mon[1]);
    // alarm flag from a lowered high threshold
    mwr(mmp_pkg::HI_ALM + 5'd1, 8'h40);
    step(4);
    cmp(34'(int_n), 34'h0);
    mrd(mmp_pkg::ALM_FLAGS, 8'h02);
    lrd(mmp_pkg::ALM_FLAGS, 8'h02, 8'h00);
    rd(mmp_pkg::ISTAT_OFF, 32'h3);
    // value back in range clears the flag and the pin
    mon[1] <= 8'h20;
    step(4);
    cmp(34'(int_n), 34'h1);
    lrd(5'd1, 8'h20, mon[2]);
    lrd(5'd3, mon[3], mon[4]);
    close_out();
  end
endmodule
`default_nettype wire
